// *** hdl/dstd_pkg.sv ***
package dstd_pkg;
  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam longint unsigned CLK_HZ = 64'd250000000;
  // reference judgement windows, nanoseconds
  localparam int unsigned REF_PER_MIN_NS = 14000;
  localparam int unsigned REF_PER_MAX_NS = 17500;
  localparam int unsigned REF_PW_MIN_NS = 2000;
  localparam int unsigned REF_PW_MAX_NS = 13000;
  localparam int unsigned HOLD_NS = 1000000000;
  // least times round up, longest times round down
  localparam int unsigned PER_MIN_CYC = (REF_PER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PER_MAX_CYC = REF_PER_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned PW_MIN_CYC = (REF_PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PW_MAX_CYC = REF_PW_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // regenerated clock
  localparam longint unsigned DPLL_HZ = 64'd3088000;
  localparam logic [31:0] NCO_NOM = 32'((DPLL_HZ << 32) / CLK_HZ);
  localparam logic [1:0] REF_DIV_LAST = 2'h3;
  localparam logic [7:0] TICK_LAST = 8'hc0;
  localparam logic [7:0] TICK_HALF = 8'h61;
  localparam logic signed [11:0] TRIM_MAX = 12'sh7ff;
  localparam logic signed [11:0] TRIM_MIN = -12'sh7ff;
  // ds1 framing
  localparam logic [7:0] BIT_LAST = 8'hc0;
  localparam logic [4:0] D4_FRM_LAST = 5'h0b;
  localparam logic [4:0] ESF_FRM_LAST = 5'h17;
  localparam logic [11:0] D4_FBITS = 12'h8dc;
  localparam logic [5:0] ESF_FPS = 6'h0b;
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam int unsigned OUT_NUM = 10;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned GAP_W = 16;
  localparam int unsigned HOLD_W = 28;

  // one bipolar symbol on a pair of rails
  typedef struct packed {
    logic pos;
    logic neg;
  } dstd_rail_type;

  typedef enum logic [1:0] {
    ST_REF0,
    ST_REF1,
    ST_FAIL
  } dstd_sel_type;
endpackage

// *** hdl/dstd_top.sv ***
// Summary of operation
// (RULE1) judge two composite references by pulse width
// (RULE2) switch to other reference when selected fails
// (RULE3) both failed: major alarm, outputs cut only when inhibit enabled
// (RULE4) recovered reference usable after one second good
// (RULE5) digital pll regenerates 3.088 MHz from reference
// (RULE6) framer builds all-ones ds1 with framing bits
// (RULE7) unipolar stream converted to bipolar dual rail
// (RULE8) output enable buffer fans out to drivers
// (RULE9) ten independent ds1 outputs
// (RULE10) enable buffer blocks outputs in inhibit mode
// (RULE11) switch one selects d4 or esf framing
// (RULE12) switch two in enables inhibit option
// (RULE13) inhibit enabled: both references bad disables outputs
// (RULE14) inhibit enabled: outputs resume when one recovers
// (RULE15) inhibit disabled: outputs keep running on failure
// (RULE16) bit rate is half clock, 193-bit frames
// (RULE17) successive ones alternate polarity on the rails
`timescale 1ns/10ps
`default_nettype none
module dstd_top
  import dstd_pkg::*;
#(
  parameter int unsigned PER_MIN = PER_MIN_CYC,
  parameter int unsigned PER_MAX = PER_MAX_CYC,
  parameter int unsigned PW_MIN = PW_MIN_CYC,
  parameter int unsigned PW_MAX = PW_MAX_CYC,
  parameter int unsigned HOLD = HOLD_CYC,
  parameter int unsigned DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire dstd_rail_type [1:0] ref_in,
  input wire logic esf_sw,
  input wire logic cutoff_sw,
  output logic [OUT_NUM-1:0] ds1_pos,
  output logic [OUT_NUM-1:0] ds1_neg,
  output logic major_alarm,
  output logic [1:0] ref_in_use,
  output logic cutoff_led
);

  // window check used for period and pulse width
  function automatic logic in_win(input logic [GAP_W-1:0] v, input int unsigned lo,
                                  input int unsigned hi);
    in_win = (v >= GAP_W'(lo)) && (v <= GAP_W'(hi));
  endfunction

  // option switches pass two flip-flops
  logic [1:0] sw_s1_ff;
  logic [1:0] sw_s2_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_s1_ff <= 2'h0;
      sw_s2_ff <= 2'h0;
    end else begin
      sw_s1_ff <= {cutoff_sw, esf_sw};
      sw_s2_ff <= sw_s1_ff;
    end
  end
  wire logic esf_mode = sw_s2_ff[0]; // RULE11
  wire logic cut_opt = sw_s2_ff[1]; // RULE12

  // per reference judgement and hysteresis
  dstd_rail_type ref_s1_ff [2];
  dstd_rail_type ref_s2_ff [2];
  logic comp_prev_ff [2];
  logic [GAP_W-1:0] gap_ff [2];
  logic [GAP_W-1:0] hi_ff [2];
  logic good_ff [2];
  logic [HOLD_W-1:0] hold_ff [2];
  logic [1:0] usable_ff;
  logic [1:0] rise_w;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ref
      wire logic comp = ref_s2_ff[gi].pos | ref_s2_ff[gi].neg;
      wire logic rise = comp & ~comp_prev_ff[gi];
      wire logic fall = ~comp & comp_prev_ff[gi];
      wire logic gap_over = gap_ff[gi] > GAP_W'(PER_MAX);
      wire logic hi_over = hi_ff[gi] > GAP_W'(PW_MAX);
      wire logic gap_ok = in_win(gap_ff[gi], PER_MIN, PER_MAX); // RULE1
      wire logic hi_ok = in_win(hi_ff[gi], PW_MIN, PW_MAX); // RULE1
      wire logic nxt_good = rise ? gap_ok :
                            fall ? (good_ff[gi] & hi_ok) :
                            (good_ff[gi] & ~gap_over & ~hi_over);
      assign rise_w[gi] = rise;
      // synchroniser and edge memory
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ref_s1_ff[gi] <= '0;
          ref_s2_ff[gi] <= '0;
          comp_prev_ff[gi] <= 1'b0;
        end else begin
          ref_s1_ff[gi] <= ref_in[gi];
          ref_s2_ff[gi] <= ref_s1_ff[gi];
          comp_prev_ff[gi] <= comp;
        end
      end
      // interval and high time counters, saturating past their limits
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          gap_ff[gi] <= '0;
          hi_ff[gi] <= '0;
          good_ff[gi] <= 1'b0;
        end else begin
          gap_ff[gi] <= rise ? GAP_W'(1) : (gap_over ? gap_ff[gi] : gap_ff[gi] + GAP_W'(1));
          hi_ff[gi] <= ~comp ? '0 : (hi_over ? hi_ff[gi] : hi_ff[gi] + GAP_W'(1));
          good_ff[gi] <= nxt_good; // RULE1
        end
      end
      // usable only after HOLD cycles of unbroken good judgement
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          hold_ff[gi] <= '0;
          usable_ff[gi] <= 1'b0;
        end else if (!good_ff[gi]) begin
          hold_ff[gi] <= '0;
          usable_ff[gi] <= 1'b0;
        end else if (!usable_ff[gi]) begin
          hold_ff[gi] <= hold_ff[gi] + HOLD_W'(1);
          usable_ff[gi] <= hold_ff[gi] == HOLD_W'(HOLD - 1); // RULE4
        end
      end
    end
  endgenerate

  // reference selection
  dstd_sel_type sel_ff;
  dstd_sel_type nxt_sel;
  always_comb begin
    nxt_sel = sel_ff;
    case (sel_ff)
      ST_REF0: if (!usable_ff[0]) nxt_sel = usable_ff[1] ? ST_REF1 : ST_FAIL; // RULE2
      ST_REF1: if (!usable_ff[1]) nxt_sel = usable_ff[0] ? ST_REF0 : ST_FAIL; // RULE2
      ST_FAIL: begin
        if (usable_ff[0]) nxt_sel = ST_REF0; // RULE14
        else if (usable_ff[1]) nxt_sel = ST_REF1;
      end
      default: nxt_sel = ST_FAIL;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sel_ff <= ST_FAIL;
    else sel_ff <= nxt_sel;
  end
  wire logic both_fail = sel_ff == ST_FAIL; // RULE3
  wire logic cut_w = cut_opt & both_fail; // RULE13 RULE15
  wire logic sel_rise = (sel_ff == ST_REF0) ? rise_w[0] :
                        (sel_ff == ST_REF1) ? rise_w[1] : 1'b0;

  // edge-triggered dpll: nco trimmed once per four reference edges
  logic [31:0] acc_ff;
  logic tick_ff;
  logic signed [11:0] trim_ff;
  logic [1:0] ref_div_ff;
  logic [7:0] tick_cnt_ff;
  wire logic [31:0] nco_inc = NCO_NOM + {{20{trim_ff[11]}}, trim_ff};
  wire logic [32:0] acc_sum = {1'b0, acc_ff} + {1'b0, nco_inc};
  wire logic cmp = sel_rise & (ref_div_ff == REF_DIV_LAST);
  wire logic fast = tick_cnt_ff < TICK_HALF;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff <= acc_sum[31:0];
      tick_ff <= acc_sum[32]; // RULE5
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_div_ff <= '0;
      tick_cnt_ff <= '0;
      trim_ff <= '0;
    end else begin
      if (sel_rise) ref_div_ff <= ref_div_ff + 2'h1;
      if (cmp) tick_cnt_ff <= '0;
      else if (tick_ff) tick_cnt_ff <= (tick_cnt_ff == TICK_LAST) ? '0 : tick_cnt_ff + 8'h1;
      if (cmp && tick_cnt_ff != 8'h0) begin // RULE5
        if (fast && trim_ff != TRIM_MIN) trim_ff <= trim_ff - 12'sh1;
        else if (!fast && trim_ff != TRIM_MAX) trim_ff <= trim_ff + 12'sh1;
      end
    end
  end

  // two-entry buffer between framer and line timing
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  dstd_rail_type buf_mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0] cnt_ff;
  logic half_ff;
  wire logic bit_start = tick_ff & ~half_ff; // RULE16
  wire logic in_ready = cnt_ff < (PTR_W + 1)'(DEPTH);
  wire logic out_valid = cnt_ff != '0;
  wire logic push = in_ready;
  wire logic pop = bit_start & out_valid;
  dstd_rail_type sym_w;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= (wr_ptr_ff == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_ff + PTR_W'(1);
      if (pop) rd_ptr_ff <= (rd_ptr_ff == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_ff + PTR_W'(1);
      cnt_ff <= cnt_ff + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end
  end
  always_ff @(posedge clk) begin
    if (push) buf_mem_ff[wr_ptr_ff] <= sym_w;
  end

  // framer: bit and frame counters, esf crc, ami polarity
  logic [7:0] bit_cnt_ff;
  logic [4:0] frm_ff;
  logic [5:0] crc_ff;
  logic [5:0] crc_prev_ff;
  logic pol_ff;
  wire logic [4:0] frm_last = esf_mode ? ESF_FRM_LAST : D4_FRM_LAST;
  wire logic frm_end = bit_cnt_ff == BIT_LAST;
  wire logic sf_end = frm_end & (frm_ff >= frm_last);
  // frame numbers beyond the d4 superframe appear only after an esf to d4 change
  wire logic d4_f = (frm_ff > D4_FRM_LAST) ? 1'b1 :
                    D4_FBITS[4'(4'hb - frm_ff[3:0])];
  wire logic esf_fps = ESF_FPS[3'(3'h5 - frm_ff[4:2])];
  wire logic esf_crc = crc_prev_ff[3'(3'h5 - frm_ff[4:2])];
  wire logic esf_f = (frm_ff[1:0] == 2'h3) ? esf_fps :
                     (frm_ff[1:0] == 2'h1) ? esf_crc : 1'b1;
  wire logic f_bit = esf_mode ? esf_f : d4_f; // RULE11
  wire logic data_bit = (bit_cnt_ff == 8'h0) ? f_bit : 1'b1; // RULE6 RULE16
  wire logic crc_fb = crc_ff[5] ^ 1'b1;
  wire logic [5:0] crc_nxt = {crc_ff[4:0], 1'b0} ^ (crc_fb ? CRC_POLY : 6'h0);
  assign sym_w.pos = data_bit & ~pol_ff; // RULE7 RULE17
  assign sym_w.neg = data_bit & pol_ff; // RULE17
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= '0;
      frm_ff <= '0;
      pol_ff <= 1'b0;
    end else if (push) begin
      bit_cnt_ff <= frm_end ? '0 : bit_cnt_ff + 8'h1; // RULE16
      if (frm_end) frm_ff <= sf_end ? '0 : frm_ff + 5'h1;
      pol_ff <= pol_ff ^ data_bit; // RULE17
    end
  end
  // crc over the superframe, framing positions taken as ones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_ff <= '0;
      crc_prev_ff <= '0;
    end else if (push) begin
      crc_ff <= sf_end ? '0 : crc_nxt;
      if (sf_end) crc_prev_ff <= crc_nxt;
    end
  end

  // line timing: mark in first half of the bit, return to zero in second
  dstd_rail_type line_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_ff <= 1'b0;
      line_ff <= '0;
    end else if (tick_ff) begin
      half_ff <= ~half_ff;
      line_ff <= (bit_start && out_valid) ? buf_mem_ff[rd_ptr_ff] : '0; // RULE7
    end
  end

  // output enable buffer fanning out to ten separate drivers
  generate
    for (gi = 0; gi < OUT_NUM; gi++) begin : g_out
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ds1_pos[gi] <= 1'b0;
          ds1_neg[gi] <= 1'b0;
        end else begin
          ds1_pos[gi] <= line_ff.pos & ~cut_w; // RULE8 RULE9 RULE10
          ds1_neg[gi] <= line_ff.neg & ~cut_w; // RULE8 RULE9 RULE10
        end
      end
    end
  endgenerate

  // status indications
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      major_alarm <= 1'b0;
      ref_in_use <= 2'h0;
      cutoff_led <= 1'b0;
    end else begin
      major_alarm <= both_fail; // RULE3
      ref_in_use <= {sel_ff == ST_REF1, sel_ff == ST_REF0};
      cutoff_led <= cut_w;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_SWITCH: assert property (sel_ff == ST_REF0 && !usable_ff[0] && usable_ff[1] |=> // RULE2
    sel_ff == ST_REF1) else $error("no switch to second reference");
  AST_ALARM: assert property (usable_ff == 2'h0 |=> ##1 major_alarm) // RULE3
    else $error("major alarm missing on dual failure");
  AST_HOLD: assert property ($rose(usable_ff[0]) |-> $past(hold_ff[0]) == HOLD_W'(HOLD - 1) // RULE4
    && $past(good_ff[0])) else $error("reference usable before hold time");
  AST_TRIM: assert property (cmp && tick_cnt_ff != 8'h0 && fast && trim_ff != TRIM_MIN |=> // RULE5
    trim_ff == $past(trim_ff) - 12'sh1) else $error("fast nco not slowed");
  AST_PAYLOAD: assert property (push && bit_cnt_ff != 8'h0 |-> sym_w.pos ^ sym_w.neg) // RULE6
    else $error("payload bit not a mark");
  AST_RAILS: assert property (!(line_ff.pos && line_ff.neg)) // RULE7
    else $error("both rails marked");
  AST_FANOUT: assert property (ds1_pos == {OUT_NUM{ds1_pos[0]}} && // RULE9
    ds1_neg == {OUT_NUM{ds1_neg[0]}}) else $error("outputs differ");
  AST_CUT: assert property (cut_opt && both_fail |=> ds1_pos == '0 && ds1_neg == '0) // RULE13
    else $error("outputs not cut off");
  AST_NOCUT: assert property (!cut_opt |=> ds1_pos[0] == $past(line_ff.pos)) // RULE15
    else $error("output blocked without inhibit option");
  AST_RESUME: assert property (both_fail && usable_ff != 2'h0 |=> !both_fail) // RULE14
    else $error("no resume after reference recovery");
  AST_AMI: assert property (push && data_bit |=> pol_ff != $past(pol_ff)) // RULE17
    else $error("polarity not alternated");
  AST_STAY: assert property (sel_ff == ST_REF1 && usable_ff[1] |=> sel_ff == ST_REF1) // RULE2
    else $error("left a usable second reference");
  AST_HOLD_B: assert property ($rose(usable_ff[1]) |-> // RULE4
    $past(hold_ff[1]) == HOLD_W'(HOLD - 1) && $past(good_ff[1]))
    else $error("second reference usable before hold time");
  AST_RZ: assert property (tick_ff && half_ff |=> line_ff == '0) // RULE7
    else $error("second half of bit not zero");
  AST_FRAME: assert property (push && frm_end |=> bit_cnt_ff == 8'h0) // RULE16
    else $error("frame longer than its bit count");
  AST_CUT_LED: assert property (cut_opt && both_fail |=> cutoff_led) // RULE13
    else $error("inhibit indication missing");

  COV_SWITCH: cover property (sel_ff == ST_REF0 ##1 sel_ff == ST_REF1);
  COV_FAIL: cover property (sel_ff != ST_FAIL ##1 sel_ff == ST_FAIL);
  COV_CUT: cover property ($rose(cut_w));
  COV_ESF_SF: cover property (esf_mode && push && sf_end);

endmodule // dstd_top
`default_nettype wire

// *** verif/dstd_feed_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// reference feed card: composite clock whose marks alternate between the rails
module dstd_feed_model
  import dstd_pkg::*;
#(
  parameter real PHASE = 3.0
) (
  input wire logic [1:0] mode,
  output var dstd_rail_type line
);
  logic on_neg = 1'b0;

  // mode 0 silent, 1 good 40 ns marks, 2 marks too wide to pass
  initial begin
    line = '0;
    #(PHASE);
    forever begin
      if (mode == 2'h0) begin
        #80.0;
      end else begin
        line = on_neg ? 2'b01 : 2'b10;
        on_neg = ~on_neg;
        #((mode == 2'h2) ? 76.0 : 40.0);
        line = '0;
        #((mode == 2'h2) ? 4.0 : 40.0);
      end
    end
  end
endmodule // dstd_feed_model
`default_nettype wire

// *** verif/tb_ds1_timing_distributor.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_ds1_timing_distributor
  import dstd_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic esf_sw = 1'b0;
  logic cutoff_sw = 1'b0;
  logic [1:0] mode_a = 2'h0;
  logic [1:0] mode_b = 2'h0;
  wire dstd_rail_type ref_a;
  wire dstd_rail_type ref_b;
  logic [OUT_NUM-1:0] ds1_pos;
  logic [OUT_NUM-1:0] ds1_neg;
  logic major_alarm;
  logic [1:0] ref_in_use;
  logic cutoff_led;
  int errors = 0;
  int compares = 0;
  logic [31:0] seed = 32'hd30fc70a;
  logic mark_d = 1'b0;
  logic last_neg = 1'b0;
  logic have_last = 1'b0;
  int gap = 0;
  int marks = 0;
  int longs = 0;
  wire mark = ds1_pos[0] | ds1_neg[0];

  always #2 clk = ~clk;

  dstd_feed_model #(.PHASE(3.0)) feed_a (.mode(mode_a), .line(ref_a));
  dstd_feed_model #(.PHASE(41.3)) feed_b (.mode(mode_b), .line(ref_b));

  // short reference period: 20 clk nominal, windows scaled to match
  dstd_top #(.PER_MIN(16), .PER_MAX(24), .PW_MIN(2), .PW_MAX(18), .HOLD(200)) dut (
    .clk(clk), .rst(rst), .ref_in({ref_b, ref_a}), .esf_sw(esf_sw),
    .cutoff_sw(cutoff_sw), .ds1_pos(ds1_pos), .ds1_neg(ds1_neg),
    .major_alarm(major_alarm), .ref_in_use(ref_in_use), .cutoff_led(cutoff_led));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // marks between two dropped framing bits: whole frames less one framing bit
  function automatic logic frame_ok(input int n);
    return (n % 193) == 192;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // wait for a selection; no reference in use goes with the major alarm
  task automatic wait_use(input logic [1:0] e, input int lim);
    for (int i = 0; i < lim && ref_in_use !== e; i++) @(negedge clk);
    check("ref_in_use", ref_in_use, e);
    check("major_alarm", major_alarm, e == 2'h0);
  endtask

  task automatic wait_mark(input int lim);
    for (int i = 0; i < lim && mark !== 1'b1; i++) @(negedge clk);
    check("mark", mark, 1'b1);
  endtask

  // output watch: identical fan-out, alternating marks, bit and frame spacing
  always @(negedge clk) begin
    check("fanout", {ds1_pos === {OUT_NUM{ds1_pos[0]}}, ds1_neg === {OUT_NUM{ds1_neg[0]}},
      ds1_pos[0] & ds1_neg[0]}, 3'b110);
    gap++;
    if (mark && !mark_d) begin
      if (have_last) begin
        check("polarity", ds1_neg[0], !last_neg);
        if (gap >= 160 && gap <= 164) begin
          marks++;
        end else if (gap >= 318 && gap <= 330) begin
          if (longs > 0) check("frame", frame_ok(marks), 1'b1);
          longs++;
          marks = 1;
        end else begin
          check("bit_gap", gap, 162);
        end
      end
      have_last = 1'b1;
      last_neg = ds1_neg[0];
      gap = 0;
    end
    mark_d = mark;
    if (rst || cutoff_led) have_last = 1'b0;
  end

  initial begin
    idle(3);
    rst = 1'b0;
    mode_a = 2'h1;
    mode_b = 2'h1;
    idle(2);
    check("fail_after_reset", {major_alarm, ref_in_use}, 3'b100);
    idle(150);
    check("hold", {major_alarm, ref_in_use}, 3'b100);
    wait_use(2'h1, 300);
    mode_a = 2'h2;
    wait_use(2'h2, 60);
    mode_a = 2'h1;
    seed = xs(seed);
    idle(20 + seed[6:0]);
    check("no_early_return", ref_in_use, 2'h2);
    idle(300);
    check("stay_on_b", ref_in_use, 2'h2);
    mode_b = 2'h0;
    wait_use(2'h1, 80);
    mode_a = 2'h0;
    wait_use(2'h0, 80);
    check("no_cut_led", cutoff_led, 1'b0);
    wait_mark(400);
    for (int n = 0; n < 90000 && longs < 2; n++) @(negedge clk);
    check("frames_seen", longs >= 2, 1'b1);
    cutoff_sw = 1'b1;
    seed = xs(seed);
    esf_sw = seed[0];
    idle(8);
    check("cut_led", cutoff_led, 1'b1);
    for (int n = 0; n < 400; n++) begin
      @(negedge clk);
      if (mark !== 1'b0 || n == 399) check("cut_out", {ds1_pos, ds1_neg}, 0);
    end
    mode_b = 2'h1;
    idle(150);
    check("no_early_resume", {major_alarm, ref_in_use}, 3'b100);
    check("still_cut", {ds1_pos, ds1_neg}, 0);
    wait_use(2'h2, 400);
    idle(2);
    check("cut_led_off", cutoff_led, 1'b0);
    esf_sw = ~esf_sw;
    wait_mark(400);
    finish_test();
  end
endmodule // tb_ds1_timing_distributor
`default_nettype wire
